// >>> hdl/pwm_map.vh
`ifndef PWM_MAP_VH
`define PWM_MAP_VH
`define CNT_W          16
`define CNT_RESET      16'h0000
`define ACT_NONE       2'h0
`define ACT_TOGGLE     2'h1
`define ACT_LOW        2'h2
`define ACT_HIGH       2'h3
`define EV_ZERO        0
`define EV_LOAD        1
`define EV_A_UP        2
`define EV_A_DOWN      3
`define EV_B_UP        4
`define EV_B_DOWN      5
`define EV_N           6
`define ACT_W          12
`define DB_W           12
`endif

// >>> hdl/pwm_action.v
`include "pwm_map.vh"
module pwm_action (
  input  wire                 clk_i,     // module clock
  input  wire                 reset_i,   // async reset, active high
  input  wire                 run_i,     // generator running
  input  wire [`EV_N-1:0]     event_i,   // qualified events
  input  wire [`ACT_W-1:0]    action_i,  // two bits per event
  output reg                  out_o      // generated signal
);
  reg [1:0] act;
  integer   k;

  // later events in the list win; zero and load coincide only when load is 0; one match per output at a time
  always @* begin
    act = `ACT_NONE;
    for (k = 0; k < `EV_N; k = k + 1) begin
      if (event_i[k] && action_i[2*k +: 2] != `ACT_NONE) begin
        act = action_i[2*k +: 2];
      end
    end
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_o <= 1'b0;
    end else if (!run_i) begin
      out_o <= 1'b0;
    end else begin
      case (act)
        `ACT_TOGGLE: out_o <= ~out_o;
        `ACT_LOW:    out_o <= 1'b0;
        `ACT_HIGH:   out_o <= 1'b1;
        default:     out_o <= out_o;
      endcase
    end
  end
endmodule

// >>> hdl/pwm_deadband.v
`include "pwm_map.vh"
module pwm_deadband (
  input  wire              clk_i,    // module clock
  input  wire              reset_i,  // async reset, active high
  input  wire              in_i,     // source signal
  input  wire [`DB_W-1:0]  delay_i,  // rising-edge delay in cycles
  output reg               out_o     // delayed-rise copy
);
  reg [`DB_W-1:0] count;

  // output falls with the input at once, rises only after the input stayed high delay_i cycles
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= {`DB_W{1'b0}};
      out_o <= 1'b0;
    end else if (!in_i) begin
      count <= {`DB_W{1'b0}};
      out_o <= 1'b0;
    end else if (count >= delay_i) begin
      out_o <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

// >>> hdl/pwm_gen_deadband_fault.v
// Notes on behaviour
// - down mode: load to zero, reload, repeat
// - up/down mode: zero up to load, back down
// - direction low in down mode, follows up/down
// - one-cycle pulses at zero and at load
// - compare pulses on match, direction qualified
// - compare above load never matches
// - four events down mode, six up/down
// - compare ignored when coinciding with zero/load
// - on coinciding matches A wins at first output, B at second
// - per event action: none, toggle, low, high
// - dead-band: first output gets delayed rise
// - second output inverted input, delayed rise
// - selectable interrupt and trigger event sets
// - interrupt and trigger use raw events
// - global reset returns counter to start
// - immediate updates take effect at zero
// - synchronous updates wait for update request
// - per-output fault enable forces inactive
// - debug stall: halt at zero or run
// - single enable mask gates pin outputs
// - per-output optional inversion at pins
// - counter and load are 16 bits
// - update request self-clears, software cannot
// - disabled output becomes zero before inversion
// - sync bit resets counter, then self-clears
`include "pwm_map.vh"
module pwm_gen_deadband_fault (
  input  wire                clk_i,                  // module clock, 200 MHz
  input  wire                reset_i,                // async reset, active high
  input  wire                run_i,                  // generator enable
  input  wire                mode_updown_i,          // 1 up/down, 0 down
  input  wire                update_sync_mode_i,     // 1 synchronous updates
  input  wire                global_update_set_i,    // pulse: request global update
  input  wire                counter_sync_set_i,     // pulse: request counter reset
  input  wire [`CNT_W-1:0]   load_i,                 // new load value
  input  wire [`CNT_W-1:0]   cmp_a_i,                // new compare A
  input  wire [`CNT_W-1:0]   cmp_b_i,                // new compare B
  input  wire                values_write_i,         // pulse: load/compare written
  input  wire [`ACT_W-1:0]   action_first_i,         // actions for first output
  input  wire [`ACT_W-1:0]   action_second_i,        // actions for second output
  input  wire                deadband_en_i,          // dead-band enable
  input  wire [`DB_W-1:0]    rise_delay_i,           // first output rise delay
  input  wire [`DB_W-1:0]    fall_delay_i,           // second output rise delay
  input  wire [`EV_N-1:0]    int_select_i,           // interrupt event set
  input  wire [`EV_N-1:0]    trig_select_i,          // trigger event set
  input  wire                fault_i,                // fault pin, asynchronous
  input  wire                fault_int_en_i,         // fault raises interrupt
  input  wire [1:0]          fault_enable_mask_i,    // per-output fault enable
  input  wire                debug_stall_i,          // debugger stall
  input  wire                stall_run_i,            // 1 keep counting in stall
  input  wire [1:0]          output_enable_mask_i,   // pin enables
  input  wire [1:0]          output_invert_mask_i,   // pin inversion
  output reg                 pin_out_first_o,        // first pin
  output reg                 pin_out_second_o,       // second pin
  output reg                 irq_o,                  // one-cycle event interrupt
  output reg                 fault_irq_o,            // fault interrupt level
  output reg                 trigger_o,              // one-cycle converter trigger
  output reg  [`CNT_W-1:0]   count_o,                // counter value
  output reg                 direction_o,            // 1 counting up
  output reg                 global_update_request_o,// update pending
  output reg                 counter_sync_reset_o    // sync reset pending
);
  reg [`CNT_W-1:0] load_act;
  reg [`CNT_W-1:0] cmp_a_act;
  reg [`CNT_W-1:0] cmp_b_act;
  reg [`CNT_W-1:0] load_pend;
  reg [`CNT_W-1:0] cmp_a_pend;
  reg [`CNT_W-1:0] cmp_b_pend;
  reg              pend_valid;
  reg              halted;
  reg [2:0]        fault_sync;
  reg              fault_level;
  reg [`CNT_W-1:0] next_count;
  reg              next_direction;
  reg              apply_now;

  wire gen_out_first;
  wire gen_out_second;
  wire db_first;
  wire db_second;

  wire at_zero  = (count_o == {`CNT_W{1'b0}});
  wire at_load  = (count_o == load_act);
  // a compare above load cannot be reached by the counter, so it never pulses
  wire match_a  = (count_o == cmp_a_act) && (cmp_a_act <= load_act);
  wire match_b  = (count_o == cmp_b_act) && (cmp_b_act <= load_act);
  wire edge_ev  = at_zero | at_load;
  wire counting = run_i && !halted;

  wire [`EV_N-1:0] events;
  assign events[`EV_ZERO]   = counting && at_zero;
  assign events[`EV_LOAD]   = counting && at_load;
  assign events[`EV_A_UP]   = counting && match_a && !edge_ev && mode_updown_i
                              && direction_o;
  assign events[`EV_A_DOWN] = counting && match_a && !edge_ev && !direction_o;
  assign events[`EV_B_UP]   = counting && match_b && !edge_ev && mode_updown_i
                              && direction_o;
  assign events[`EV_B_DOWN] = counting && match_b && !edge_ev && !direction_o;

  // on coinciding matches the first output takes only A and the second only B
  wire a_hit = events[`EV_A_UP] | events[`EV_A_DOWN];
  wire b_hit = events[`EV_B_UP] | events[`EV_B_DOWN];
  wire [`EV_N-1:0] ev_first  = {events[5:4] & {2{!a_hit}}, events[3:0]};
  wire [`EV_N-1:0] ev_second = {events[5:4], events[3:2] & {2{!b_hit}}, events[1:0]};

  pwm_action u_act_first (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .run_i    (run_i),
    .event_i  (ev_first),
    .action_i (action_first_i),
    .out_o    (gen_out_first)
  );

  pwm_action u_act_second (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .run_i    (run_i),
    .event_i  (ev_second),
    .action_i (action_second_i),
    .out_o    (gen_out_second)
  );

  pwm_deadband u_db_first (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .in_i     (gen_out_first),
    .delay_i  (rise_delay_i),
    .out_o    (db_first)
  );

  pwm_deadband u_db_second (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .in_i     (~gen_out_first),
    .delay_i  (fall_delay_i),
    .out_o    (db_second)
  );

  // counter next state
  always @* begin
    next_count     = count_o;
    next_direction = direction_o;
    if (mode_updown_i) begin
      if (direction_o) begin
        if (count_o >= load_act) begin
          next_direction = 1'b0;
          next_count     = (load_act == {`CNT_W{1'b0}}) ? count_o : count_o - 1'b1;
        end else begin
          next_count = count_o + 1'b1;
        end
      end else begin
        if (at_zero) begin
          next_direction = 1'b1;
          next_count     = (load_act == {`CNT_W{1'b0}}) ? count_o : count_o + 1'b1;
        end else begin
          next_count = count_o - 1'b1;
        end
      end
    end else begin
      next_direction = 1'b0;
      // a load applied at this zero is already the reload value
      next_count     = at_zero ? (apply_now ? load_pend : load_act) : count_o - 1'b1;
    end
  end

  always @* begin
    apply_now = counting && at_zero && pend_valid &&
                (!update_sync_mode_i || global_update_request_o);
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o                 <= `CNT_RESET;
      direction_o             <= 1'b0;
      halted                  <= 1'b0;
      load_act                <= {`CNT_W{1'b0}};
      cmp_a_act               <= {`CNT_W{1'b0}};
      cmp_b_act               <= {`CNT_W{1'b0}};
      load_pend               <= {`CNT_W{1'b0}};
      cmp_a_pend              <= {`CNT_W{1'b0}};
      cmp_b_pend              <= {`CNT_W{1'b0}};
      pend_valid              <= 1'b0;
      global_update_request_o <= 1'b0;
      counter_sync_reset_o    <= 1'b0;
    end else begin
      if (values_write_i) begin
        load_pend  <= load_i;
        cmp_a_pend <= cmp_a_i;
        cmp_b_pend <= cmp_b_i;
        pend_valid <= 1'b1;
      end else if (apply_now) begin
        pend_valid <= 1'b0;
      end
      if (apply_now) begin
        load_act  <= load_pend;
        cmp_a_act <= cmp_a_pend;
        cmp_b_act <= cmp_b_pend;
      end
      // set wins over the self-clear; software has no clear path
      if (global_update_set_i) begin
        global_update_request_o <= 1'b1;
      end else if (counting && at_zero) begin
        global_update_request_o <= 1'b0;
      end
      // stall may only halt once the counter has come back to zero
      if (!debug_stall_i || stall_run_i) begin
        halted <= 1'b0;
      end else if (!stall_run_i && at_zero && run_i) begin
        halted <= 1'b1;
      end
      if (counter_sync_set_i || counter_sync_reset_o) begin
        count_o              <= `CNT_RESET;
        direction_o          <= 1'b0;
        counter_sync_reset_o <= counter_sync_set_i;
      end else if (counting && !(debug_stall_i && !stall_run_i && at_zero)) begin
        count_o     <= next_count;
        direction_o <= next_direction;
      end
    end
  end

  // fault pin: three stages, level changes once stages two and three agree
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_sync  <= 3'h0;
      fault_level <= 1'b0;
    end else begin
      fault_sync <= {fault_sync[1:0], fault_i};
      if (fault_sync[1] == fault_sync[2]) begin
        fault_level <= fault_sync[2];
      end
    end
  end

  wire sel_first  = deadband_en_i ? db_first  : gen_out_first;
  wire sel_second = deadband_en_i ? db_second : gen_out_second;
  wire en_first   = output_enable_mask_i[0] && !(fault_level && fault_enable_mask_i[0]);
  wire en_second  = output_enable_mask_i[1] && !(fault_level && fault_enable_mask_i[1]);

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_out_first_o  <= 1'b0;
      pin_out_second_o <= 1'b0;
      irq_o            <= 1'b0;
      trigger_o        <= 1'b0;
      fault_irq_o      <= 1'b0;
    end else begin
      pin_out_first_o  <= (sel_first  & en_first)  ^ output_invert_mask_i[0];
      pin_out_second_o <= (sel_second & en_second) ^ output_invert_mask_i[1];
      // a stall without stall_run_i halts counting at zero, so it then produces no events and no interrupt
      irq_o            <= |(events & int_select_i);
      trigger_o        <= |(events & trig_select_i);
      fault_irq_o      <= fault_level && fault_int_en_i;
    end
  end
endmodule

// >>> dv/power_stage_model.sv
module power_stage_model (
  input  wire logic high_side_i, // upper switch gate
  input  wire logic low_side_i,  // lower switch gate
  input  wire logic clk_i,       // module clock
  input  wire logic trip_i,      // overcurrent trip asked for by the bench
  output logic      fault_o,     // fault line back to the generator
  output int        shoot_o      // cycles with both switches on
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    fault_o = 1'b0;
    shoot_o = 0;
  end
  // the stage cannot know the intended dead time, so it only counts overlap
  always @(posedge clk_i) begin
    fault_o <= trip_i;
    if (high_side_i && low_side_i) shoot_o <= shoot_o + 1;
  end
endmodule

// >>> dv/pwm_gen_deadband_fault_monitor.sv
`include "pwm_map.vh"
module pwm_gen_deadband_fault_monitor (
  input wire logic              clk_i, // clock
  input wire logic              reset_i, // reset
  input wire logic              run_i, // run
  input wire logic              mode_updown_i, // mode
  input wire logic              counter_sync_set_i, // sync request
  input wire logic [`EV_N-1:0]  int_select_i, // irq events
  input wire logic              fault_i, // fault pin
  input wire logic [1:0]        fault_enable_mask_i, // fault enables
  input wire logic              debug_stall_i, // stall
  input wire logic [1:0]        output_enable_mask_i, // pin enables
  input wire logic [1:0]        output_invert_mask_i, // pin inversion
  input wire logic              pin_out_first_o, // first pin
  input wire logic              pin_out_second_o, // second pin
  input wire logic              irq_o, // interrupt
  input wire logic [`CNT_W-1:0] count_o, // counter
  input wire logic              direction_o, // direction
  input wire logic              global_update_request_o, // update pending
  input wire logic              counter_sync_reset_o // sync pending
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_down_step: assert property (
    run_i && !mode_updown_i && !direction_o && !debug_stall_i && !counter_sync_set_i
    && count_o != 0 |=> count_o == $past(count_o) - 1'b1) else $error("bad down step");
  a_dir_low: assert property (
    !mode_updown_i && !$past(mode_updown_i) && $past(run_i) |-> !direction_o)
    else $error("direction high in down mode");
  a_sync_zero: assert property (
    counter_sync_set_i |=> counter_sync_reset_o && count_o == 0) else $error("sync missed");
  a_sync_clear: assert property (
    counter_sync_reset_o && !counter_sync_set_i |=> !counter_sync_reset_o)
    else $error("sync flag stuck");
  a_update_hold: assert property (
    global_update_request_o && count_o != 0 |=> global_update_request_o)
    else $error("update request dropped early");
  a_irq_zero: assert property (
    run_i && !debug_stall_i && count_o == 0 && int_select_i[`EV_ZERO] |=> irq_o)
    else $error("zero event interrupt missing");
  // inversion must be settled too, the pins register it one cycle late
  a_fault_force: assert property (
    (fault_i && fault_enable_mask_i[0] && $stable(output_invert_mask_i)) [*6]
    |-> pin_out_first_o == output_invert_mask_i[0]) else $error("fault did not force pin");
  a_enable_off: assert property (
    (!output_enable_mask_i[1] && $stable(output_invert_mask_i)) [*3]
    |-> pin_out_second_o == output_invert_mask_i[1]) else $error("disabled pin not zero");
endmodule
bind pwm_gen_deadband_fault pwm_gen_deadband_fault_monitor mon (
  .clk_i, .reset_i, .run_i, .mode_updown_i, .counter_sync_set_i, .int_select_i, .fault_i,
  .fault_enable_mask_i, .debug_stall_i, .output_enable_mask_i, .output_invert_mask_i,
  .pin_out_first_o, .pin_out_second_o, .irq_o, .count_o, .direction_o,
  .global_update_request_o, .counter_sync_reset_o);

// >>> dv/pwm_gen_deadband_fault_tb_top.sv
`include "pwm_map.vh"
module pwm_gen_deadband_fault_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i, reset_i, run_i, mode_updown_i, update_sync_mode_i, global_update_set_i;
  logic        counter_sync_set_i, values_write_i, deadband_en_i, fault_i, fault_int_en_i;
  logic        debug_stall_i, stall_run_i, trip, pin_out_first_o, pin_out_second_o, irq_o;
  logic        fault_irq_o, trigger_o, direction_o, global_update_request_o;
  logic        counter_sync_reset_o;
  logic [15:0] load_i, cmp_a_i, cmp_b_i, count_o;
  logic [11:0] action_first_i, action_second_i, rise_delay_i, fall_delay_i;
  logic [5:0]  int_select_i, trig_select_i;
  logic [1:0]  fault_enable_mask_i, output_enable_mask_i, output_invert_mask_i;
  int          fails, check_count, cyc, ni, nt, n1, n2, shoot, s0;
  // first code, second code, enables, inversions, then expected pins
  logic [9:0]  rows [5] = '{10'h3b2, 10'h2fe, 10'h031, 10'h3db, 10'h3a6};
  pwm_gen_deadband_fault dut (.*);
  power_stage_model stage (.clk_i, .high_side_i(pin_out_first_o), .low_side_i(pin_out_second_o),
                           .trip_i(trip), .fault_o(fault_i), .shoot_o(shoot));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_cnt(input logic [15:0] v);
    int k = 0;
    while (count_o !== v && k < 300) begin
      tick(1);
      k++;
    end
    chk(count_o, v);
  endtask
  task automatic put(input logic [15:0] ld, input logic [15:0] a, input logic [15:0] b);
    {load_i, cmp_a_i, cmp_b_i, values_write_i} = {ld, a, b, 1'b1};
    tick(1);
    values_write_i = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic count_win(input int n);
    {ni, nt, n1, n2} = '0;
    repeat (n) begin
      tick(1);
      {ni, nt, n1, n2} = {ni + irq_o, nt + trigger_o, n1 + pin_out_first_o, n2 + pin_out_second_o};
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("[ERR] %0t run hung", $time);
      stop_test();
    end
  end
  initial begin
    {run_i, mode_updown_i, update_sync_mode_i, global_update_set_i, counter_sync_set_i,
     values_write_i, deadband_en_i, fault_int_en_i, debug_stall_i, stall_run_i, trip} = '0;
    {load_i, cmp_a_i, cmp_b_i, action_first_i, action_second_i, rise_delay_i, fall_delay_i,
     int_select_i, trig_select_i, fault_enable_mask_i, output_invert_mask_i} = '0;
    {output_enable_mask_i, reset_i} = {2'h3, 1'b1};
    tick(5);
    {reset_i, run_i} = 2'b01;
    put(16'h0007, 16'h0003, 16'h0005);
    foreach (rows[r]) begin
      {action_first_i, action_second_i} = {{6{rows[r][9:8]}}, {6{rows[r][7:6]}}};
      {output_enable_mask_i, output_invert_mask_i} = rows[r][5:2];
      tick(12);
      chk(pin_out_first_o, rows[r][1]);
      chk(pin_out_second_o, rows[r][0]);
    end
    {action_first_i, output_enable_mask_i, output_invert_mask_i} = {12'h001, 2'h3, 2'h0};
    count_win(16);
    chk(n1, 8);
    $display("output stage done");
    {int_select_i, trig_select_i} = {6'h03, 6'h08};
    wait_cnt(16'h0007);
    for (int i = 6; i >= -1; i--) begin
      tick(1);
      chk(count_o, (i < 0) ? 16'h0007 : 16'(i));
    end
    chk(irq_o, 1'b1);
    tick(1);
    chk(irq_o, 1'b1);
    count_win(16);
    chk(ni, 4);
    chk(nt, 2);
    $display("down count done");
    {mode_updown_i, int_select_i, trig_select_i} = {1'b1, 6'h08, 6'h04};
    wait_cnt(16'h0000);
    for (int i = 1; i <= 14; i++) begin
      tick(1);
      chk(count_o, 16'((i <= 7) ? i : 14 - i));
      if (i == 2 || i == 12) chk(direction_o, i == 2);
    end
    count_win(28);
    chk(ni, 2);
    chk(nt, 2);
    put(16'h0007, 16'h0000, 16'h0009);
    int_select_i = 6'h3c;
    // the new compares only apply at the next zero
    wait_cnt(16'h0000);
    wait_cnt(16'h0007);
    count_win(28);
    chk(ni, 0);
    $display("up down done");
    mode_updown_i = 1'b0;
    wait_cnt(16'h0002);
    put(16'h0005, 16'h0003, 16'h0005);
    chk(count_o, 16'h0001);
    tick(2);
    chk(count_o, 16'h0005);
    update_sync_mode_i = 1'b1;
    put(16'h0003, 16'h0001, 16'h0001);
    wait_cnt(16'h0000);
    tick(1);
    chk(count_o, 16'h0005);
    wait_cnt(16'h0004);
    pulse(global_update_set_i);
    chk(global_update_request_o, 1'b1);
    wait_cnt(16'h0000);
    tick(1);
    chk(count_o, 16'h0003);
    chk(global_update_request_o, 1'b0);
    update_sync_mode_i = 1'b0;
    $display("updates done");
    put(16'h000f, 16'h0008, 16'h0008);
    {action_first_i, action_second_i} = {12'h083, 12'hfff};
    {rise_delay_i, fall_delay_i, deadband_en_i} = {12'h002, 12'h003, 1'b1};
    wait_cnt(16'h000f);
    tick(16);
    s0 = shoot;
    count_win(32);
    chk(n1, 12);
    chk(n2, 10);
    chk(shoot - s0, 0);
    $display("dead band done");
    {fault_enable_mask_i, fault_int_en_i, trip} = 4'b0111;
    tick(8);
    count_win(16);
    chk(n1, 0);
    chk(n2, 5);
    chk(fault_irq_o, 1'b1);
    output_invert_mask_i = 2'h1;
    tick(2);
    count_win(16);
    chk(n1, 16);
    {trip, fault_enable_mask_i, output_invert_mask_i, deadband_en_i, fault_int_en_i} = '0;
    $display("fault done");
    debug_stall_i = 1'b1;
    tick(40);
    chk(count_o, 16'h0000);
    stall_run_i = 1'b1;
    tick(3);
    chk(count_o == 16'h0000, 1'b0);
    {debug_stall_i, stall_run_i} = '0;
    $display("stall done");
    wait_cnt(16'h0009);
    pulse(counter_sync_set_i);
    chk(counter_sync_reset_o, 1'b1);
    chk(count_o, 16'h0000);
    tick(1);
    chk(counter_sync_reset_o, 1'b0);
    wait_cnt(16'h0009);
    reset_i = 1'b1;
    tick(1);
    chk(count_o, 16'h0000);
    reset_i = 1'b0;
    $display("sync and reset done");
    stop_test();
  end
endmodule
